// ===== rtl/rtcc_defs.svh
`ifndef RTCC_DEFS_SVH
`define RTCC_DEFS_SVH

// bus target address, 7-bit form (write byte D0h)
`define RTCC_DEV_ADDR 7'h68

// byte indexes of the clock map
`define RTCC_IDX_SEC 3'h0
`define RTCC_IDX_MIN 3'h1
`define RTCC_IDX_HOUR 3'h2
`define RTCC_IDX_DAY 3'h3
`define RTCC_IDX_DATE 3'h4
`define RTCC_IDX_MONTH 3'h5
`define RTCC_IDX_YEAR 3'h6
`define RTCC_IDX_CALIB 3'h7

// field positions
`define RTCC_CENT_BIT 6
`define RTCC_HOUR_MSB 5

// bcd limits
`define RTCC_MAX_SEC 8'h59
`define RTCC_MAX_MIN 8'h59
`define RTCC_MAX_HOUR 6'h23
`define RTCC_MAX_DAY 8'h07
`define RTCC_MAX_MONTH 8'h12
`define RTCC_MAX_YEAR 8'h99
`define RTCC_MONTH_FEB 8'h02
`define RTCC_MONTH_APR 8'h04
`define RTCC_MONTH_JUN 8'h06
`define RTCC_MONTH_SEP 8'h09
`define RTCC_MONTH_NOV 8'h11
`define RTCC_DAYS_31 8'h31
`define RTCC_DAYS_30 8'h30
`define RTCC_DAYS_29 8'h29
`define RTCC_DAYS_28 8'h28

// reset values
`define RTCC_RST_ZERO 8'h00
`define RTCC_RST_ONE 8'h01

// crystal rate in Hz; one tick per this many crystal edges
`define RTCC_XTAL_HZ 32768

`endif

// ===== rtl/rtcc_pkg.sv
package rtcc_pkg;

    typedef enum logic [7:0] {
        RTCC_ST_IDLE = 8'h01,
        RTCC_ST_DEV = 8'h02,
        RTCC_ST_ACKA = 8'h04,
        RTCC_ST_RX = 8'h08,
        RTCC_ST_ACKR = 8'h10,
        RTCC_ST_TX = 8'h20,
        RTCC_ST_ACKT = 8'h40,
        RTCC_ST_WAIT = 8'h80
    } rtcc_state_t;

    typedef struct packed {
        logic [7:0] calib;
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] day;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } rtcc_time_t;

endpackage

// ===== rtl/rtcc_top.sv
`timescale 1ns/1ps
`include "rtcc_defs.svh"

// Summary of operation
// - A crystal clock at 32.768 kHz is divided down to a one-second tick that advances the calendar.
// - Eight bytes hold the clock, calendar and calibration; the seven clock and calendar bytes count in BCD.
// - The byte pointer steps by one after every data byte written or read on the serial bus.
// - Hours count 00 to 23 in BCD and the wrap carries into day and date.
// - The date rolls over at the end of 28, 30 and 31 day months without software.
// - February has 29 days in every year divisible by four.
// - The serial port is an I2C target good for fast mode bus clocks.
// - Only the 7-bit address whose write byte is D0h is answered.
// - Bytes are seconds, minutes, century/hours, day, date, month, year, calibration in that order.
// - The pointer moves only on the acknowledge clock and is kept between transfers.
// - The user copy freezes while pointer 00h to 06h is in use and resumes on stop or at 07h.
module rtcc_top #(
    parameter int XTAL_DIV = `RTCC_XTAL_HZ
) (
    // system
    input wire logic mclk,
    input wire logic rst,
    // crystal
    input wire logic crystal_in,
    // serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // live calendar
    output rtcc_pkg::rtcc_time_t time_now
);
    import rtcc_pkg::*;

    // crystal domain: divider only, so the tick is a toggle crossed into mclk
    logic [1:0] xrst_sync;
    logic [15:0] xdiv;
    logic tick_tgl;

    always_ff @(posedge crystal_in) begin
        xrst_sync <= {xrst_sync[0], rst};
    end

    always_ff @(posedge crystal_in) begin
        if (xrst_sync[1]) begin
            xdiv <= 16'h0000;
            tick_tgl <= 1'b0;
        end else if (xdiv == 16'(XTAL_DIV - 1)) begin
            xdiv <= 16'h0000;
            tick_tgl <= ~tick_tgl;
        end else begin
            xdiv <= xdiv + 16'h0001;
        end
    end

    // mclk domain synchronisers
    // the third stage of each line only feeds the edge detectors below
    logic tgl_s1, tgl_s2, tgl_s3;
    logic scl_s1, scl_s2, scl_s3;
    logic sda_s1, sda_s2, sda_s3;

    always_ff @(posedge mclk) begin
        if (rst) begin
            tgl_s1 <= 1'b0;
            tgl_s2 <= 1'b0;
            tgl_s3 <= 1'b0;
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_s3 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_s3 <= 1'b1;
        end else begin
            tgl_s1 <= tick_tgl;
            tgl_s2 <= tgl_s1;
            tgl_s3 <= tgl_s2;
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_s3 <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
        end
    end

    // 100 MHz oversampling leaves ample margin at 400 kHz bus clocks
    wire tick = tgl_s2 ^ tgl_s3;
    wire scl_rise = scl_s2 & ~scl_s3;
    wire scl_fall = ~scl_s2 & scl_s3;
    wire start_c = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
    wire stop_c = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;

    // calendar counters and the user copy
    logic [7:0] cnt [8];
    logic [7:0] shadow [8];
    logic [7:0] next_cnt [8];

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    wire [7:0] year = cnt[`RTCC_IDX_YEAR];
    wire [7:0] month = cnt[`RTCC_IDX_MONTH];
    wire [5:0] hour = cnt[`RTCC_IDX_HOUR][`RTCC_HOUR_MSB:0];
    // hours share their byte with the century bit, so only the low six bits count
    wire [7:0] hour_inc = bcd_inc({2'b00, hour});
    // every fourth year, valid before 2100
    wire leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                        : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
    wire short_month = month == `RTCC_MONTH_APR || month == `RTCC_MONTH_JUN
                     || month == `RTCC_MONTH_SEP || month == `RTCC_MONTH_NOV;
    wire [7:0] month_end = (month == `RTCC_MONTH_FEB) ? (leap ? `RTCC_DAYS_29 : `RTCC_DAYS_28)
                         : (short_month ? `RTCC_DAYS_30 : `RTCC_DAYS_31);

    wire c_sec = tick;
    wire w_sec = cnt[`RTCC_IDX_SEC] == `RTCC_MAX_SEC;
    wire c_min = c_sec & w_sec;
    wire w_min = cnt[`RTCC_IDX_MIN] == `RTCC_MAX_MIN;
    wire c_hour = c_min & w_min;
    wire w_hour = hour == `RTCC_MAX_HOUR;
    wire c_date = c_hour & w_hour;
    wire w_day = cnt[`RTCC_IDX_DAY] == `RTCC_MAX_DAY;
    wire w_date = cnt[`RTCC_IDX_DATE] == month_end;
    wire c_month = c_date & w_date;
    wire w_month = month == `RTCC_MAX_MONTH;
    wire c_year = c_month & w_month;
    wire w_year = year == `RTCC_MAX_YEAR;
    wire c_cent = c_year & w_year;

    // bus write strobe and byte, from the serial engine below
    logic wr_en;
    logic [2:0] ptr;
    // index of the byte in flight: ptr has already moved on when the strobe lands
    logic [2:0] wr_ptr;
    logic [7:0] shreg;

    always_comb begin
        next_cnt = cnt;
        if (c_sec) next_cnt[`RTCC_IDX_SEC] = w_sec ? `RTCC_RST_ZERO : bcd_inc(cnt[`RTCC_IDX_SEC]);
        if (c_min) next_cnt[`RTCC_IDX_MIN] = w_min ? `RTCC_RST_ZERO : bcd_inc(cnt[`RTCC_IDX_MIN]);
        if (c_hour) next_cnt[`RTCC_IDX_HOUR][`RTCC_HOUR_MSB:0] = w_hour ? 6'h00 : hour_inc[5:0];
        if (c_cent) next_cnt[`RTCC_IDX_HOUR][`RTCC_CENT_BIT] = ~cnt[`RTCC_IDX_HOUR][`RTCC_CENT_BIT];
        if (c_date) next_cnt[`RTCC_IDX_DAY] = w_day ? `RTCC_RST_ONE : bcd_inc(cnt[`RTCC_IDX_DAY]);
        if (c_date) next_cnt[`RTCC_IDX_DATE] = w_date ? `RTCC_RST_ONE : bcd_inc(cnt[`RTCC_IDX_DATE]);
        if (c_month) next_cnt[`RTCC_IDX_MONTH] = w_month ? `RTCC_RST_ONE : bcd_inc(month);
        if (c_year) next_cnt[`RTCC_IDX_YEAR] = w_year ? `RTCC_RST_ZERO : bcd_inc(year);
        // a bus write overrides only the byte it names, the tick still reaches the rest
        if (wr_en) next_cnt[wr_ptr] = shreg;
    end

    // user copy held while a clock byte is addressed
    logic active;
    wire freeze = active && (ptr != `RTCC_IDX_CALIB);

    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                cnt[i] <= `RTCC_RST_ZERO;
                shadow[i] <= `RTCC_RST_ZERO;
            end
            cnt[`RTCC_IDX_DAY] <= `RTCC_RST_ONE;
            cnt[`RTCC_IDX_DATE] <= `RTCC_RST_ONE;
            cnt[`RTCC_IDX_MONTH] <= `RTCC_RST_ONE;
        end else begin
            cnt <= next_cnt;
            if (!freeze) shadow <= cnt;
        end
    end

    assign time_now = {cnt[7], cnt[6], cnt[5], cnt[4], cnt[3], cnt[2], cnt[1], cnt[0]};

    // serial target engine
    // start and stop win over any byte in progress, so a cut frame always ends cleanly
    rtcc_state_t state;
    logic [3:0] bitcnt;
    logic rw;
    logic word_phase;
    logic nack;

    wire [7:0] rd_byte = shadow[ptr];
    wire [2:0] ptr_inc = ptr + 3'h1;
    wire addr_hit = shreg[7:1] == `RTCC_DEV_ADDR;
    wire byte_done = scl_fall && bitcnt == 4'h8;

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= RTCC_ST_IDLE;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            ptr <= 3'h0;
            rw <= 1'b0;
            word_phase <= 1'b0;
            nack <= 1'b0;
            active <= 1'b0;
            wr_en <= 1'b0;
            wr_ptr <= 3'h0;
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
        end else begin
            wr_en <= 1'b0;
            if (start_c) begin
                state <= RTCC_ST_DEV;
                bitcnt <= 4'h0;
                sda_oe_n <= 1'b1;
            end else if (stop_c) begin
                state <= RTCC_ST_IDLE;
                active <= 1'b0;
                sda_oe_n <= 1'b1;
            end else begin
                unique case (state)
                    RTCC_ST_IDLE, RTCC_ST_WAIT: begin
                        sda_oe_n <= 1'b1;
                    end
                    RTCC_ST_DEV: begin
                        if (scl_rise) begin
                            shreg <= {shreg[6:0], sda_s2};
                            bitcnt <= bitcnt + 4'h1;
                        end else if (byte_done) begin
                            if (addr_hit) begin
                                state <= RTCC_ST_ACKA;
                                sda_oe_n <= 1'b0;
                                rw <= shreg[0];
                                active <= 1'b1;
                            end else begin
                                state <= RTCC_ST_WAIT;
                            end
                        end
                    end
                    RTCC_ST_ACKA: begin
                        if (scl_fall) begin
                            bitcnt <= 4'h0;
                            if (rw) begin
                                // read starts at the kept pointer
                                state <= RTCC_ST_TX;
                                shreg <= rd_byte;
                                sda_oe_n <= rd_byte[7];
                            end else begin
                                state <= RTCC_ST_RX;
                                word_phase <= 1'b1;
                                sda_oe_n <= 1'b1;
                            end
                        end
                    end
                    RTCC_ST_RX: begin
                        if (scl_rise) begin
                            shreg <= {shreg[6:0], sda_s2};
                            bitcnt <= bitcnt + 4'h1;
                        end else if (byte_done) begin
                            state <= RTCC_ST_ACKR;
                            sda_oe_n <= 1'b0;
                        end
                    end
                    RTCC_ST_ACKR: begin
                        if (scl_fall) begin
                            state <= RTCC_ST_RX;
                            bitcnt <= 4'h0;
                            sda_oe_n <= 1'b1;
                            word_phase <= 1'b0;
                            if (word_phase) begin
                                // addresses above 07h fold into the eight bytes
                                ptr <= shreg[2:0];
                            end else begin
                                wr_en <= 1'b1;
                                wr_ptr <= ptr;
                                ptr <= ptr_inc;
                            end
                        end
                    end
                    RTCC_ST_TX: begin
                        if (scl_fall) begin
                            bitcnt <= bitcnt + 4'h1;
                            shreg <= {shreg[6:0], 1'b1};
                            if (bitcnt == 4'h7) begin
                                state <= RTCC_ST_ACKT;
                                sda_oe_n <= 1'b1;
                            end else begin
                                sda_oe_n <= shreg[6];
                            end
                        end
                    end
                    RTCC_ST_ACKT: begin
                        if (scl_rise) begin
                            nack <= sda_s2;
                            ptr <= ptr_inc;
                        end else if (scl_fall) begin
                            bitcnt <= 4'h0;
                            if (nack) begin
                                // master ends the read, line left high for its stop
                                state <= RTCC_ST_WAIT;
                            end else begin
                                state <= RTCC_ST_TX;
                                shreg <= rd_byte;
                                sda_oe_n <= rd_byte[7];
                            end
                        end
                    end
                endcase
            end
        end
    end

endmodule

// ===== verification/rtcc_top_asserts.sv
`timescale 1ns/1ps
module rtcc_top_asserts #(
    parameter int XTAL_DIV = 32768
) (
    // system
    input wire logic mclk,
    input wire logic rst,
    input wire logic crystal_in,
    // bus
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    // calendar
    input wire rtcc_pkg::rtcc_time_t time_now
);
    import rtcc_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence sec_wrap;
        $past(time_now.sec) == 8'h59 && time_now.sec == 8'h00;
    endsequence
    sequence hour_wrap;
        $past(time_now.hour[5:0]) == 6'h23 && time_now.hour[5:0] == 6'h00;
    endsequence
    AST_RESET_STATE: assert property ($fell(rst) |-> sda_oe_n && time_now == 64'h0000010101000000)
        else $error("bad state after reset");
    AST_BCD_DIGITS: assert property (time_now.sec[3:0] <= 4'h9 && time_now.min[3:0] <= 4'h9
        && time_now.date[3:0] <= 4'h9 && time_now.year[3:0] <= 4'h9) else $error("digit not bcd");
    AST_HOUR_RANGE: assert property (time_now.hour[5:0] <= 6'h23)
        else $error("hour beyond 23");
    AST_SEC_CARRY: assert property (sec_wrap |-> time_now.min != $past(time_now.min))
        else $error("seconds wrap without minute carry");
    AST_DAY_CARRY: assert property (hour_wrap |-> time_now.date != $past(time_now.date)
        && time_now.day != $past(time_now.day)) else $error("hour wrap without day carry");
    AST_MONTH_END: assert property ($past(time_now.date) != 8'h01 && time_now.date == 8'h01
        |-> time_now.month != $past(time_now.month)) else $error("date roll without month carry");
    AST_YEAR_CARRY: assert property ($past(time_now.month) == 8'h12 && time_now.month == 8'h01
        |-> time_now.year != $past(time_now.year)) else $error("month wrap without year carry");
    AST_CENTURY: assert property ($past(time_now.year) == 8'h99 && time_now.year == 8'h00
        |-> time_now.hour[6] != $past(time_now.hour[6])) else $error("century bit kept");
    AST_DRIVE_ON_LOW: assert property (!$stable(sda_oe_n) |-> !scl_in)
        else $error("data drive changed while clock high");
endmodule

// ===== verification/rtcc_i2c_master.sv
`timescale 1ns/1ps
module rtcc_i2c_master #(
    parameter int QTR = 63
) (
    // clock
    input wire logic mclk,
    // bus
    input wire logic sda_wire,
    output logic scl,
    output logic sda_rel
);
    // quarter bit of 63 mclk keeps scl just under 400 kHz
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic q();
        repeat (QTR) @(posedge mclk);
        #1;
    endtask
    // data moves only while scl is low
    task automatic bit_io(input logic d, output logic s);
        sda_rel = d;
        q();
        scl = 1'b1;
        q();
        s = sda_wire;
        q();
        scl = 1'b0;
        q();
    endtask
    task automatic start();
        sda_rel = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_rel = 1'b0;
        q();
        scl = 1'b0;
        q();
    endtask
    task automatic stop();
        sda_rel = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_rel = 1'b1;
        q();
    endtask
    task automatic wr(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask
    task automatic rd(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(!ack, s);
    endtask
endmodule

// ===== verification/rtcc_top_test.sv
`timescale 1ns/1ps
module rtcc_top_test;
    import rtcc_pkg::*;
    logic mclk, rst, crystal_in, xtal_run, scl, sda_rel, sda_in, sda_out, sda_oe_n, a;
    logic [7:0] b;
    logic [31:0] rnd = 32'h0000000B;
    rtcc_time_t time_now, e;
    int fails, check_count, cycles, n, sec, min, hr, day, date, mon, yr, cent;
    int tm[4] = '{2, 2, 4, 12};
    int td[4] = '{28, 28, 30, 31};
    int ty[4] = '{4, 5, 10, 99};
    // pull-up on data; either side may pull low
    assign sda_in = sda_rel & (sda_oe_n | sda_out);
    rtcc_top #(.XTAL_DIV(4)) i_rtcc_top (.mclk(mclk), .rst(rst), .crystal_in(crystal_in), .scl_in(scl),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .time_now(time_now));
    rtcc_i2c_master i_rtcc_i2c_master (.mclk(mclk), .sda_wire(sda_in), .scl(scl), .sda_rel(sda_rel));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // crystal idles between bursts so each burst is an exact tick count
    initial begin
        crystal_in = 1'b0;
        #1.3;
        forever #3 crystal_in = xtal_run & ~crystal_in;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 130000) begin
            fails++;
            results();
        end
    end
    function automatic int rand_to(input int m);
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return int'(rnd % m);
    endfunction
    function automatic logic [7:0] bcd(input int v);
        return 8'(v / 10 * 16 + v % 10);
    endfunction
    function automatic rtcc_time_t model();
        return {8'h00, bcd(yr), bcd(mon), bcd(date), bcd(day), bcd(hr) | 8'(cent * 64), bcd(min), bcd(sec)};
    endfunction
    function automatic int mdays();
        if (mon == 2) return (yr % 4 == 0) ? 29 : 28;
        return (mon == 4 || mon == 6 || mon == 9 || mon == 11) ? 30 : 31;
    endfunction
    task automatic model_tick();
        sec = (sec + 1) % 60;
        if (sec == 0) min = (min + 1) % 60;
        if (sec == 0 && min == 0) hr = (hr + 1) % 24;
        if (sec == 0 && min == 0 && hr == 0) begin
            day = day % 7 + 1;
            date = (date == mdays()) ? 1 : date + 1;
            if (date == 1) mon = mon % 12 + 1;
            if (date == 1 && mon == 1) yr = (yr + 1) % 100;
            if (date == 1 && mon == 1 && yr == 0) cent = 1 - cent;
        end
    endtask
    task automatic run_ticks(input int t);
        repeat (t) begin
            xtal_run = 1'b1;
            repeat (4) @(posedge crystal_in);
            xtal_run = 1'b0;
            repeat (6) @(posedge mclk);
            #1;
            model_tick();
        end
    endtask
    task automatic check_time(input rtcc_time_t exp);
        check_count++;
        if (time_now !== exp) begin
            fails++;
            $display("wrong value time_now expected %h seen %h", exp, time_now);
        end
    endtask
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        xtal_run = 1'b1;
        repeat (8) @(posedge mclk);
        #1;
        xtal_run = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        check_time(64'h0000010101000000);
        rst = 1'b0;
        xtal_run = 1'b1;
        repeat (5) @(posedge mclk);
        #1;
        xtal_run = 1'b0;
        repeat (6) @(posedge mclk);
        #1;
        for (int k = 0; k < 4; k++) begin
            sec = 59;
            min = 59;
            hr = 23;
            cent = 0;
            day = 1 + rand_to(7);
            date = td[k];
            mon = tm[k];
            yr = ty[k];
            e = model();
            i_rtcc_i2c_master.start();
            i_rtcc_i2c_master.wr(8'hD0, a);
            check_byte("address ack", 8'h01, 8'(a));
            i_rtcc_i2c_master.wr(8'h00, a);
            for (int i = 0; i < 7; i++) begin
                i_rtcc_i2c_master.wr(e[8 * i +: 8], a);
                check_byte("data ack", 8'h01, 8'(a));
            end
            i_rtcc_i2c_master.stop();
            check_time(e);
            run_ticks(1 + rand_to(3));
            check_time(model());
            $display("calendar test %0d done", k);
        end
        // split read: the second part starts where the pointer was left
        n = 1 + rand_to(7);
        e = model();
        i_rtcc_i2c_master.start();
        i_rtcc_i2c_master.wr(8'hD0, a);
        i_rtcc_i2c_master.wr(8'h00, a);
        i_rtcc_i2c_master.start();
        i_rtcc_i2c_master.wr(8'hD1, a);
        run_ticks(1);
        for (int i = 0; i < 8; i++) begin
            if (i == n) begin
                i_rtcc_i2c_master.stop();
                i_rtcc_i2c_master.start();
                i_rtcc_i2c_master.wr(8'hD1, a);
                e = model();
            end
            i_rtcc_i2c_master.rd(i != n - 1 && i != 7, b);
            check_byte("read byte", e[8 * i +: 8], b);
        end
        i_rtcc_i2c_master.stop();
        check_time(model());
        $display("read test done");
        b = 8'(rand_to(256));
        if (b[7:1] == 7'h68) b = 8'h52;
        i_rtcc_i2c_master.start();
        i_rtcc_i2c_master.wr(b, a);
        check_byte("foreign address ack", 8'h00, 8'(a));
        i_rtcc_i2c_master.stop();
        $display("address test done");
        results();
    end
endmodule
bind rtcc_top rtcc_top_asserts #(.XTAL_DIV(XTAL_DIV)) i_rtcc_top_asserts (.mclk(mclk), .rst(rst),
    .crystal_in(crystal_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .time_now(time_now));
